// ---- common/rtcc_pkg.sv ----
/*
 * Constants for the calendar clock: field ranges, defaults, timing counts.
 * Assumes a single 250 MHz system clock and word-wide register ports.
 */
// Summary of operation
// - With the year select clear, the year reads as its last two digits.
// - With the year select set, the year reads as two digits plus 2000.
// - The half-minute correction fires only on a rising request edge.
// - Correction at seconds 0 to 29 keeps minutes and zeroes seconds.
// - Correction at seconds 30 to 59 adds a minute and zeroes seconds.
// - Fields stay within their ranges: 0-59, 0-23, 1-31, 1-12, 1-7, 0-99.
// - An invalid written setting loads zeros and ones as the default date.
// - Stored time is retained across power loss and resumes afterwards.
// - Without backup, time advances only while powered.
// - Time is written by the time-write instruction or a programming port.
package rtcc_pkg;
    localparam int RTCC_CLK_HZ = 250_000_000;
    localparam int RTCC_TICK_S = 1;
    localparam int RTCC_TICK_CYC = RTCC_CLK_HZ * RTCC_TICK_S;
    localparam logic [15:0] RTCC_YEAR_BASE = 16'h07D0;
    localparam logic [7:0] RTCC_SEC_MAX = 8'h3B;
    localparam logic [7:0] RTCC_MIN_MAX = 8'h3B;
    localparam logic [7:0] RTCC_HOUR_MAX = 8'h17;
    localparam logic [7:0] RTCC_DAY_MAX = 8'h1F;
    localparam logic [7:0] RTCC_MON_MAX = 8'h0C;
    localparam logic [7:0] RTCC_WDAY_MAX = 8'h07;
    localparam logic [7:0] RTCC_YEAR_MAX = 8'h63;
    localparam logic [7:0] RTCC_SEC_HALF = 8'h1E;
    localparam logic [7:0] RTCC_RST_ZERO = 8'h00;
    localparam logic [7:0] RTCC_RST_ONE = 8'h01;
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] mon;
        logic [7:0] wday;
        logic [7:0] year;
    } rtcc_time_s;
endpackage : rtcc_pkg

// ---- common/rtcc_tick_if.sv ----
/*
 * Carrier for the one-second tick between divider and clock core.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ns
interface rtcc_tick_if;
    logic run;
    logic tick;
    modport src (input run, output tick);
    modport dst (output run, input tick);
endinterface : rtcc_tick_if

// ---- rtl/rtcc_divider.sv ----
/*
 * One-second enable divider.
 * Assumes clk_sys at the rate given in the package.
 */
`timescale 1ns/1ns
module rtcc_divider
    import rtcc_pkg::*;
#(
    parameter int DIV_CYC = RTCC_TICK_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    rtcc_tick_if.src tk
);
    logic [31:0] cnt_reg;

    // Counts only while powered and running
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 32'h0;
            tk.tick <= 1'b0;
        end else if (!tk.run) begin
            tk.tick <= 1'b0;
        end else if (cnt_reg == 32'(DIV_CYC - 1)) begin
            cnt_reg <= 32'h0;
            tk.tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tk.tick <= 1'b0;
        end
    end
endmodule : rtcc_divider

// ---- rtl/rtcc_core.sv ----
/*
 * Calendar clock core: seven word registers, correction, year display.
 * Assumes retention across power loss is provided by the state cells
 * themselves; reset marks power-up and loads the default date, as does an invalid write.
 */
`timescale 1ns/1ns
module rtcc_core
    import rtcc_pkg::*;
#(
    parameter int DIV_CYC = RTCC_TICK_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic powered,
    input wire logic year_offset_select,
    input wire logic half_minute_correct_request,
    input wire logic time_write_instruction,
    input wire logic periph_write,
    input wire logic [15:0] wr_seconds,
    input wire logic [15:0] wr_minutes,
    input wire logic [15:0] wr_hours,
    input wire logic [15:0] wr_day_of_month,
    input wire logic [15:0] wr_month,
    input wire logic [15:0] wr_weekday,
    input wire logic [15:0] wr_year,
    output logic [15:0] rtc_seconds,
    output logic [15:0] rtc_minutes,
    output logic [15:0] rtc_hours,
    output logic [15:0] rtc_day_of_month,
    output logic [15:0] rtc_month,
    output logic [15:0] rtc_weekday,
    output logic [15:0] rtc_year,
    output logic write_invalid
);
    rtcc_time_s t_reg;
    rtcc_time_s t_next;
    rtcc_time_s t_tick;
    logic corr_d_reg;
    logic corr_rise;
    logic corr_high;
    logic wr_any;
    logic wr_ok;
    logic [7:0] mlen;
    logic leap;
    rtcc_tick_if tk ();

    assign tk.run = powered;

    rtcc_divider #(
        .DIV_CYC(DIV_CYC)
    ) u_div (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tk(tk)
    );

    // Rising edge of the correction request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            corr_d_reg <= 1'b0;
        end else begin
            corr_d_reg <= half_minute_correct_request;
        end
    end
    assign corr_rise = half_minute_correct_request & ~corr_d_reg;
    // Upper half of the minute: correction rounds up to the next minute
    assign corr_high = corr_rise & (t_reg.sec >= RTCC_SEC_HALF);

    // Days in the current month; years kept as two digits, 00 is leap
    always_comb begin
        leap = (t_reg.year[1:0] == 2'b00);
        case (t_reg.mon)
            8'h04, 8'h06, 8'h09, 8'h0B: mlen = 8'h1E;
            8'h02: mlen = leap ? 8'h1D : 8'h1C;
            default: mlen = RTCC_DAY_MAX;
        endcase
    end

    // Write strobes and range check on the written setting
    assign wr_any = time_write_instruction | periph_write;
    assign wr_ok = (wr_seconds <= 16'(RTCC_SEC_MAX))
        && (wr_minutes <= 16'(RTCC_MIN_MAX))
        && (wr_hours <= 16'(RTCC_HOUR_MAX))
        && (wr_day_of_month >= 16'(RTCC_RST_ONE))
        && (wr_day_of_month <= 16'(RTCC_DAY_MAX))
        && (wr_month >= 16'(RTCC_RST_ONE))
        && (wr_month <= 16'(RTCC_MON_MAX))
        && (wr_weekday >= 16'(RTCC_RST_ONE))
        && (wr_weekday <= 16'(RTCC_WDAY_MAX))
        && (wr_year <= 16'(RTCC_YEAR_MAX));

    // Cascade of one second into the calendar; also the forced minute carry
    always_comb begin
        t_tick = t_reg;
        if (t_reg.sec >= RTCC_SEC_MAX || corr_high) begin
            t_tick.sec = RTCC_RST_ZERO;
            if (t_reg.min >= RTCC_MIN_MAX) begin
                t_tick.min = RTCC_RST_ZERO;
                if (t_reg.hour >= RTCC_HOUR_MAX) begin
                    t_tick.hour = RTCC_RST_ZERO;
                    t_tick.wday = (t_reg.wday >= RTCC_WDAY_MAX) ?
                        RTCC_RST_ONE : t_reg.wday + 8'h01;
                    if (t_reg.day >= mlen) begin
                        t_tick.day = RTCC_RST_ONE;
                        if (t_reg.mon >= RTCC_MON_MAX) begin
                            t_tick.mon = RTCC_RST_ONE;
                            t_tick.year = (t_reg.year >= RTCC_YEAR_MAX) ?
                                RTCC_RST_ZERO : t_reg.year + 8'h01;
                        end else begin
                            t_tick.mon = t_reg.mon + 8'h01;
                        end
                    end else begin
                        t_tick.day = t_reg.day + 8'h01;
                    end
                end else begin
                    t_tick.hour = t_reg.hour + 8'h01;
                end
            end else begin
                t_tick.min = t_reg.min + 8'h01;
            end
        end else begin
            t_tick.sec = t_reg.sec + 8'h01;
        end
    end

    // Next state: write beats correction beats tick
    always_comb begin
        t_next = t_reg;
        if (wr_any) begin
            if (wr_ok) begin
                t_next.sec = wr_seconds[7:0];
                t_next.min = wr_minutes[7:0];
                t_next.hour = wr_hours[7:0];
                t_next.day = wr_day_of_month[7:0];
                t_next.mon = wr_month[7:0];
                t_next.wday = wr_weekday[7:0];
                t_next.year = wr_year[7:0];
            end else begin
                t_next.sec = RTCC_RST_ZERO;
                t_next.min = RTCC_RST_ZERO;
                t_next.hour = RTCC_RST_ZERO;
                t_next.day = RTCC_RST_ONE;
                t_next.mon = RTCC_RST_ONE;
                t_next.wday = RTCC_RST_ONE;
                t_next.year = RTCC_RST_ZERO;
            end
        end else if (corr_rise) begin
            if (t_reg.sec < RTCC_SEC_HALF) begin
                t_next.sec = RTCC_RST_ZERO;
            end else begin
                t_next = t_tick;
            end
        end else if (tk.tick) begin
            t_next = t_tick;
        end
    end

    // Time state; held unless written, corrected or ticked
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            t_reg <= '{RTCC_RST_ZERO, RTCC_RST_ZERO, RTCC_RST_ZERO,
                RTCC_RST_ONE, RTCC_RST_ONE, RTCC_RST_ONE, RTCC_RST_ZERO};
        end else begin
            t_reg <= t_next;
        end
    end

    // Registered word outputs and year display
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rtc_seconds <= 16'(RTCC_RST_ZERO);
            rtc_minutes <= 16'(RTCC_RST_ZERO);
            rtc_hours <= 16'(RTCC_RST_ZERO);
            rtc_day_of_month <= 16'(RTCC_RST_ONE);
            rtc_month <= 16'(RTCC_RST_ONE);
            rtc_weekday <= 16'(RTCC_RST_ONE);
            rtc_year <= 16'(RTCC_RST_ZERO);
            write_invalid <= 1'b0;
        end else begin
            rtc_seconds <= {8'h00, t_reg.sec};
            rtc_minutes <= {8'h00, t_reg.min};
            rtc_hours <= {8'h00, t_reg.hour};
            rtc_day_of_month <= {8'h00, t_reg.day};
            rtc_month <= {8'h00, t_reg.mon};
            rtc_weekday <= {8'h00, t_reg.wday};
            rtc_year <= year_offset_select ?
                RTCC_YEAR_BASE + {8'h00, t_reg.year} :
                {8'h00, t_reg.year};
            if (wr_any) begin
                write_invalid <= ~wr_ok;
            end
        end
    end
endmodule : rtcc_core

// ---- test/rtcc_core_sva.sv ----
/* Port assertions for the calendar clock core.
   Assumes one clk_sys domain and arst_n active low. */
`timescale 1ns/1ns
module rtcc_core_sva
    import rtcc_pkg::*;
#(
    parameter int DIV_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic powered,
    input wire logic year_offset_select,
    input wire logic half_minute_correct_request,
    input wire logic time_write_instruction,
    input wire logic periph_write,
    input wire logic [15:0] wr_seconds,
    input wire logic [15:0] rtc_seconds,
    input wire logic [15:0] rtc_minutes,
    input wire logic [15:0] rtc_hours,
    input wire logic [15:0] rtc_day_of_month,
    input wire logic [15:0] rtc_year,
    input wire logic write_invalid
);
    logic [7:0] calm_reg;
    logic wr;
    logic req;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    assign wr = time_write_instruction || periph_write;
    assign req = half_minute_correct_request;
    // History of cycles with no write and no power
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) calm_reg <= 8'h00;
        else calm_reg <= {calm_reg[6:0], !(wr || powered)};
    end
    // Request edge while nothing else moves the time
    sequence s_edge;
        (&calm_reg) && !wr && $rose(req);
    endsequence
    a_sec_range: assert property (rtc_seconds <= 16'h003B)
        else $error("seconds out of range");
    a_hour_range: assert property (rtc_hours <= 16'h0017)
        else $error("hours out of range");
    a_year_plain: assert property ($past(arst_n, 2) && !year_offset_select
        && !$past(year_offset_select) && !$past(year_offset_select, 2)
        |-> rtc_year <= 16'h0063) else $error("plain year too big");
    a_year_offset: assert property ($past(arst_n, 2) && year_offset_select
        && $past(year_offset_select) && $past(year_offset_select, 2)
        |-> rtc_year >= 16'h07D0 && rtc_year <= 16'h0833)
        else $error("offset year out of span");
    a_corr_low: assert property (s_edge ##0 rtc_seconds < 16'h001E
        |-> ##2 rtc_seconds == 16'h0000
        && rtc_minutes == $past(rtc_minutes, 2)) else $error("low fix wrong");
    a_corr_high: assert property (s_edge ##0 rtc_seconds >= 16'h001E
        && rtc_minutes < 16'h003B |-> ##2 rtc_seconds == 16'h0000
        && rtc_minutes == $past(rtc_minutes, 2) + 16'h0001)
        else $error("high fix wrong");
    a_corr_level: assert property ((&calm_reg) && req && $past(req)
        && $past(req, 2) |=> $stable(rtc_seconds) && $stable(rtc_minutes))
        else $error("held request corrected");
    a_bad_write: assert property (wr && wr_seconds > 16'h003B
        |-> ##2 write_invalid && rtc_seconds == 16'h0000
        && rtc_day_of_month == 16'h0001) else $error("no default date");
    a_time_frozen: assert property ((&calm_reg) && !req && !$past(req)
        |=> $stable(rtc_seconds)) else $error("time moved unpowered");
endmodule : rtcc_core_sva

bind rtcc_core rtcc_core_sva #(.DIV_CYC(DIV_CYC)) u_sva (.clk_sys(clk_sys),
    .arst_n(arst_n), .powered(powered), .periph_write(periph_write),
    .year_offset_select(year_offset_select), .wr_seconds(wr_seconds),
    .half_minute_correct_request(half_minute_correct_request),
    .time_write_instruction(time_write_instruction),
    .rtc_seconds(rtc_seconds), .rtc_minutes(rtc_minutes),
    .rtc_hours(rtc_hours), .rtc_day_of_month(rtc_day_of_month),
    .rtc_year(rtc_year), .write_invalid(write_invalid));

// ---- test/tb_top.sv ----
/* Self-checking bench for the calendar clock core.
   Assumes the core alone, with the tick divider shortened to 8. */
`timescale 1ns/1ns
module tb_top;
    import rtcc_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic powered = 1'b0;
    logic year_offset_select = 1'b0;
    logic half_minute_correct_request = 1'b0;
    logic time_write_instruction = 1'b0;
    logic periph_write = 1'b0;
    logic [55:0] wr_v = 56'h0;
    wire logic [15:0] wr_seconds = {8'h00, wr_v[55:48]};
    wire logic [15:0] wr_minutes = {8'h00, wr_v[47:40]};
    wire logic [15:0] wr_hours = {8'h00, wr_v[39:32]};
    wire logic [15:0] wr_day_of_month = {8'h00, wr_v[31:24]};
    wire logic [15:0] wr_month = {8'h00, wr_v[23:16]};
    wire logic [15:0] wr_weekday = {8'h00, wr_v[15:8]};
    wire logic [15:0] wr_year = {8'h00, wr_v[7:0]};
    logic [15:0] rtc_seconds, rtc_minutes, rtc_hours, rtc_day_of_month;
    logic [15:0] rtc_month, rtc_weekday, rtc_year;
    logic write_invalid;
    wire logic [111:0] seen_v = {rtc_seconds, rtc_minutes, rtc_hours,
        rtc_day_of_month, rtc_month, rtc_weekday, rtc_year};
    int fails = 0;
    int compares = 0;
    logic [55:0] bad [3] = '{56'h3C050505050505, 56'h05051805050505,
        56'h050505050D0505};
    logic [55:0] ins [4] = '{56'h3B3B171F0C0763, 56'h3B3B171C020301,
        56'h3B3B171E040205, 56'h3B3B171C020104};
    logic [55:0] outs [4] = '{56'h00000001010100, 56'h00000001030401,
        56'h00000001050305, 56'h0000001D020204};
    rtcc_core #(.DIV_CYC(8)) dut_u (.clk_sys, .arst_n, .powered,
        .year_offset_select, .half_minute_correct_request,
        .time_write_instruction, .periph_write, .wr_seconds, .wr_minutes,
        .wr_hours, .wr_day_of_month, .wr_month, .wr_weekday, .wr_year,
        .rtc_seconds, .rtc_minutes, .rtc_hours, .rtc_day_of_month,
        .rtc_month, .rtc_weekday, .rtc_year, .write_invalid);
    // Clock at 4 ns
    always #2 clk_sys = ~clk_sys;
    function automatic logic [111:0] widen(logic [55:0] v);
        logic [111:0] r;
        for (int b = 0; b < 7; b++) r[16*b +: 16] = {8'h00, v[8*b +: 8]};
        return r;
    endfunction : widen
    task automatic check(string nm, logic [111:0] seen, logic [111:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One write strobe, then wait out the answer
    task automatic set_time(bit pw, logic [55:0] v);
        @(negedge clk_sys);
        wr_v = v;
        time_write_instruction = !pw;
        periph_write = pw;
        @(negedge clk_sys);
        time_write_instruction = 1'b0;
        periph_write = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : set_time
    // Fresh rising edge of the request after a quiet spell, left high
    task automatic correct();
        half_minute_correct_request = 1'b0;
        repeat (9) @(negedge clk_sys);
        half_minute_correct_request = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : correct
    // Power up until one second passes
    task automatic tick_once();
        logic [15:0] was;
        was = rtc_seconds;
        powered = 1'b1;
        for (int i = 0; i < 40 && rtc_seconds === was; i++) @(negedge clk_sys);
        powered = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : tick_once
    task finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // Watchdog
    initial begin
        #20000;
        fails++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        check("reset", seen_v, widen(56'h00000001010100));
        set_time(1'b0, 56'h1D0A171F0C0763);
        check("write", seen_v, widen(56'h1D0A171F0C0763));
        year_offset_select = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("year", {96'h0, rtc_year}, {96'h0, 16'h0833});
        year_offset_select = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("year", {96'h0, rtc_year}, {96'h0, 16'h0063});
        $display("test write and year done");
        correct();
        check("fix low", seen_v, widen(56'h000A171F0C0763));
        set_time(1'b1, 56'h2D0A171F0C0763);
        check("held", seen_v, widen(56'h2D0A171F0C0763));
        correct();
        check("fix high", seen_v, widen(56'h000B171F0C0763));
        half_minute_correct_request = 1'b0;
        $display("test correction done");
        for (int k = 0; k < 3; k++) begin
            set_time(1'b0, 56'h1D0A171F0C0763);
            check("flag ok", {111'h0, write_invalid}, 112'h0);
            set_time(1'b1, bad[k]);
            check("bad", seen_v, widen(56'h00000001010100));
            check("flag", {111'h0, write_invalid}, 112'h1);
        end
        $display("test invalid done");
        for (int k = 0; k < 4; k++) begin
            set_time(1'b0, ins[k]);
            tick_once();
            check("roll", seen_v, widen(outs[k]));
        end
        repeat (30) @(negedge clk_sys);
        check("hold", seen_v, widen(outs[3]));
        $display("test rollover done");
        finish_test();
    end
endmodule : tb_top
